//--- rtl/umh_chan.sv
// one channel: status tracking, change flags, terminal ready drive
// assumes modem lines already synchronous to i_clk_sys
`timescale 1ns/10ps
`include "umh_map.svh"
module umh_chan (
  input  wire logic           i_clk_sys,
  input  wire logic           i_rst_b,
  input  wire logic           i_cts_b,
  input  wire logic           i_dsr_b,
  input  wire logic           i_dcd_b,
  input  wire logic           i_msr_rd,
  input  wire logic           i_mcr_dtr,
  input  wire logic           i_loopback,
  input  wire logic           i_ms_int_en,
  output logic                o_dtr_b,
  output umh_pkg::umh_byte_t  o_modem_status_reg,
  output logic                o_irq
);
  import umh_pkg::*;

  typedef struct packed {
    umh_lines_t prev;
    logic       cts_chg;
    logic       dsr_chg;
    logic       dcd_chg;
    logic       dtr_b;
    logic       irq;
    umh_byte_t  modem_status_reg;
  } umh_state_t;

  umh_state_t s_q;
  umh_state_t s_d;
  logic       cts_ev;
  logic       dsr_ev;
  logic       dcd_ev;

  // ==========================================
  // next state
  always_comb begin
    s_d = s_q;
    cts_ev = i_cts_b != s_q.prev.cts;
    dsr_ev = i_dsr_b != s_q.prev.dsr;
    dcd_ev = i_dcd_b != s_q.prev.dcd;
    s_d.prev.cts = i_cts_b;
    s_d.prev.dsr = i_dsr_b;
    s_d.prev.dcd = i_dcd_b;
    s_d.dsr_chg = dsr_ev | (s_q.dsr_chg & ~i_msr_rd);
    s_d.cts_chg = cts_ev | (s_q.cts_chg & ~i_msr_rd);
    s_d.dcd_chg = dcd_ev | (s_q.dcd_chg & ~i_msr_rd);
    s_d.modem_status_reg = `UMH_MSR_RST;
    s_d.modem_status_reg[`UMH_MSR_DSR] = ~i_dsr_b;
    s_d.modem_status_reg[`UMH_MSR_CTS] = ~i_cts_b;
    s_d.modem_status_reg[`UMH_MSR_DCD] = ~i_dcd_b;
    s_d.modem_status_reg[`UMH_MSR_DSR_CHG] = s_d.dsr_chg;
    s_d.modem_status_reg[`UMH_MSR_CTS_CHG] = s_d.cts_chg;
    s_d.modem_status_reg[`UMH_MSR_DCD_CHG] = s_d.dcd_chg;
    s_d.irq = i_ms_int_en & (s_d.dsr_chg | s_d.cts_chg | s_d.dcd_chg);
    s_d.dtr_b = i_loopback ? `UMH_LINE_IDLE : ~i_mcr_dtr;
  end

  // ==========================================
  // registers
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s_q.prev    <= {3{`UMH_LINE_IDLE}};
      s_q.cts_chg <= `UMH_FLAG_CLR;
      s_q.dsr_chg <= `UMH_FLAG_CLR;
      s_q.dcd_chg <= `UMH_FLAG_CLR;
      s_q.dtr_b   <= `UMH_LINE_IDLE;
      s_q.irq     <= `UMH_FLAG_CLR;
      s_q.modem_status_reg     <= `UMH_MSR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_dtr_b            = s_q.dtr_b;
  assign o_modem_status_reg = s_q.modem_status_reg;
  assign o_irq              = s_q.irq;

  // ==========================================
  // checks
  a_dsr_inverse: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b |=> o_modem_status_reg[`UMH_MSR_DSR] == ~$past(i_dsr_b))
    else $error("set ready bit not inverse of input");
  a_dsr_change: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_dsr_b) |=> o_modem_status_reg[`UMH_MSR_DSR_CHG])
    else $error("set ready change not flagged");
  a_irq_follow: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b |-> o_irq == ($past(i_ms_int_en) && (o_modem_status_reg[`UMH_MSR_DSR_CHG]
      || o_modem_status_reg[`UMH_MSR_CTS_CHG] || o_modem_status_reg[`UMH_MSR_DCD_CHG])))
    else $error("interrupt disagrees with flags");
  a_dtr_drive: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b && !i_loopback && i_mcr_dtr |=> !o_dtr_b)
    else $error("terminal ready not active");
  a_dtr_loop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_loopback |=> o_dtr_b)
    else $error("terminal ready active in loopback");
  a_cts_change: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_cts_b) |=> o_modem_status_reg[`UMH_MSR_CTS_CHG])
    else $error("clear to send change not flagged");
  a_dcd_change: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_dcd_b) |=> o_modem_status_reg[`UMH_MSR_DCD_CHG])
    else $error("carrier change not flagged");
  a_read_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_msr_rd && !(i_cts_b != s_q.prev.cts) && !(i_dsr_b != s_q.prev.dsr)
      && !(i_dcd_b != s_q.prev.dcd)
      |=> !o_irq && !s_q.dsr_chg && !s_q.cts_chg && !s_q.dcd_chg)
    else $error("read did not clear flags");
endmodule

//--- rtl/umh_map.svh
// constants of the modem handshake block
// assumes inclusion by the design files
`ifndef UMH_MAP_SVH
`define UMH_MAP_SVH
`define UMH_MSR_CTS_CHG  0
`define UMH_MSR_DSR_CHG  1
`define UMH_MSR_DCD_CHG  3
`define UMH_MSR_CTS      4
`define UMH_MSR_DSR      5
`define UMH_MSR_DCD      7
`define UMH_MCR_DTR      0
`define UMH_MSR_RST      8'h00
`define UMH_MCR_RST      1'h0
`define UMH_LINE_IDLE    1'h1
`define UMH_FLAG_CLR     1'h0
`endif

//--- rtl/umh_pkg.sv
// types of the modem handshake block
// assumes umh_map.svh is on the include path
package umh_pkg;
  typedef logic [7:0] umh_byte_t;
  typedef struct packed {
    logic cts;
    logic dsr;
    logic dcd;
  } umh_lines_t;
endpackage

//--- rtl/umh_top.sv
// modem handshake logic of two serial channels
// assumes modem inputs synchronous to i_clk_sys; reads pulse one cycle
`timescale 1ns/10ps
`include "umh_map.svh"
// Operation
// - Status bit 5 reads the inverse of the set-ready input.
// - Status bit 1 sets when set-ready changed since the last status read.
// - The interrupt rises when the set-ready change flag is set and enabled.
// - Terminal-ready is driven low while its channel's control bit is 1 and loopback is off, high otherwise.
// - Reset forces terminal-ready high.
// - Loopback holds terminal-ready high.
// - Status bit 4 is inverse clear-to-send, bit 0 flags its change.
// - Status bit 7 is inverse carrier-detect, bit 3 flags its change.
// - The clear-to-send change flag raises the enabled interrupt.
// - The carrier change flag raises the enabled interrupt.
module umh_top (
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  input  wire logic [1:0]           i_cts_b,
  input  wire logic [1:0]           i_dsr_b,
  input  wire logic [1:0]           i_dcd_b,
  input  wire logic [1:0]           i_msr_rd,
  input  wire logic [1:0]           i_modem_control_reg,
  input  wire logic [1:0]           i_loopback,
  input  wire logic [1:0]           i_ms_int_en,
  output logic [1:0]                o_dtr_b,
  output umh_pkg::umh_byte_t        o_modem_status_reg_0,
  output umh_pkg::umh_byte_t        o_modem_status_reg_1,
  output logic [1:0]                o_irq
);
  import umh_pkg::*;

  // ==========================================
  // channels
  umh_chan u_ch0 (
    .i_clk_sys          (i_clk_sys),
    .i_rst_b            (i_rst_b),
    .i_cts_b            (i_cts_b[0]),
    .i_dsr_b            (i_dsr_b[0]),
    .i_dcd_b            (i_dcd_b[0]),
    .i_msr_rd           (i_msr_rd[0]),
    .i_mcr_dtr          (i_modem_control_reg[0]),
    .i_loopback         (i_loopback[0]),
    .i_ms_int_en        (i_ms_int_en[0]),
    .o_dtr_b            (o_dtr_b[0]),
    .o_modem_status_reg (o_modem_status_reg_0),
    .o_irq              (o_irq[0])
  );
  umh_chan u_ch1 (
    .i_clk_sys          (i_clk_sys),
    .i_rst_b            (i_rst_b),
    .i_cts_b            (i_cts_b[1]),
    .i_dsr_b            (i_dsr_b[1]),
    .i_dcd_b            (i_dcd_b[1]),
    .i_msr_rd           (i_msr_rd[1]),
    .i_mcr_dtr          (i_modem_control_reg[1]),
    .i_loopback         (i_loopback[1]),
    .i_ms_int_en        (i_ms_int_en[1]),
    .o_dtr_b            (o_dtr_b[1]),
    .o_modem_status_reg (o_modem_status_reg_1),
    .o_irq              (o_irq[1])
  );

  // ==========================================
  // channel 0 checks
  a_ch0_dsr_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b
    |=> o_modem_status_reg_0[`UMH_MSR_DSR] == !$past(i_dsr_b[0]))
    else $error("channel 0 set ready level wrong");

  a_ch0_cts_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b
    |=> o_modem_status_reg_0[`UMH_MSR_CTS] == !$past(i_cts_b[0]))
    else $error("channel 0 clear to send level wrong");

  a_ch0_dcd_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b
    |=> o_modem_status_reg_0[`UMH_MSR_DCD] == !$past(i_dcd_b[0]))
    else $error("channel 0 carrier level wrong");

  a_ch0_dsr_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_dsr_b[0])
    |=> o_modem_status_reg_0[`UMH_MSR_DSR_CHG])
    else $error("channel 0 set ready change missed");

  a_ch0_cts_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_cts_b[0])
    |=> o_modem_status_reg_0[`UMH_MSR_CTS_CHG])
    else $error("channel 0 clear to send change missed");

  a_ch0_dcd_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_dcd_b[0])
    |=> o_modem_status_reg_0[`UMH_MSR_DCD_CHG])
    else $error("channel 0 carrier change missed");

  a_ch0_flag_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b && o_modem_status_reg_0[`UMH_MSR_DSR_CHG] && !i_msr_rd[0]
    |=> o_modem_status_reg_0[`UMH_MSR_DSR_CHG])
    else $error("channel 0 set ready change lost");

  a_ch0_read_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_msr_rd[0] && $stable(i_cts_b[0]) && $stable(i_dsr_b[0])
      && $stable(i_dcd_b[0])
    |=> !o_irq[0] && !o_modem_status_reg_0[`UMH_MSR_CTS_CHG]
      && !o_modem_status_reg_0[`UMH_MSR_DSR_CHG] && !o_modem_status_reg_0[`UMH_MSR_DCD_CHG])
    else $error("channel 0 read left a change flag");

  a_ch0_irq_dsr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_ms_int_en[0] && $changed(i_dsr_b[0])
    |=> o_irq[0])
    else $error("channel 0 no interrupt on set ready change");

  a_ch0_irq_cts: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_ms_int_en[0] && $changed(i_cts_b[0])
    |=> o_irq[0])
    else $error("channel 0 no interrupt on clear to send change");

  a_ch0_irq_dcd: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_ms_int_en[0] && $changed(i_dcd_b[0])
    |=> o_irq[0])
    else $error("channel 0 no interrupt on carrier change");

  a_ch0_irq_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_ms_int_en[0]
    |=> !o_irq[0])
    else $error("channel 0 interrupt while disabled");

  a_ch0_dtr_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b && !i_loopback[0] && i_modem_control_reg[0]
    |=> !o_dtr_b[0])
    else $error("channel 0 terminal ready not driven");

  a_ch0_dtr_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_modem_control_reg[0]
    |=> o_dtr_b[0])
    else $error("channel 0 terminal ready driven while off");

  a_ch0_dtr_loop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_loopback[0]
    |=> o_dtr_b[0])
    else $error("channel 0 terminal ready driven in loopback");

  a_ch0_dtr_reset: assert property (@(posedge i_clk_sys)
    !i_rst_b
    |-> o_dtr_b[0] && !o_irq[0] && o_modem_status_reg_0 == `UMH_MSR_RST)
    else $error("channel 0 outputs not idle in reset");

  // ==========================================
  // channel 1 checks
  a_ch1_dsr_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b
    |=> o_modem_status_reg_1[`UMH_MSR_DSR] == !$past(i_dsr_b[1]))
    else $error("channel 1 set ready level wrong");

  a_ch1_cts_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b
    |=> o_modem_status_reg_1[`UMH_MSR_CTS] == !$past(i_cts_b[1]))
    else $error("channel 1 clear to send level wrong");

  a_ch1_dcd_level: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b
    |=> o_modem_status_reg_1[`UMH_MSR_DCD] == !$past(i_dcd_b[1]))
    else $error("channel 1 carrier level wrong");

  a_ch1_dsr_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_dsr_b[1])
    |=> o_modem_status_reg_1[`UMH_MSR_DSR_CHG])
    else $error("channel 1 set ready change missed");

  a_ch1_cts_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_cts_b[1])
    |=> o_modem_status_reg_1[`UMH_MSR_CTS_CHG])
    else $error("channel 1 clear to send change missed");

  a_ch1_dcd_flag: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && $changed(i_dcd_b[1])
    |=> o_modem_status_reg_1[`UMH_MSR_DCD_CHG])
    else $error("channel 1 carrier change missed");

  a_ch1_flag_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b && o_modem_status_reg_1[`UMH_MSR_DSR_CHG] && !i_msr_rd[1]
    |=> o_modem_status_reg_1[`UMH_MSR_DSR_CHG])
    else $error("channel 1 set ready change lost");

  a_ch1_read_clear: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_msr_rd[1] && $stable(i_cts_b[1]) && $stable(i_dsr_b[1])
      && $stable(i_dcd_b[1])
    |=> !o_irq[1] && !o_modem_status_reg_1[`UMH_MSR_CTS_CHG]
      && !o_modem_status_reg_1[`UMH_MSR_DSR_CHG] && !o_modem_status_reg_1[`UMH_MSR_DCD_CHG])
    else $error("channel 1 read left a change flag");

  a_ch1_irq_dsr: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_ms_int_en[1] && $changed(i_dsr_b[1])
    |=> o_irq[1])
    else $error("channel 1 no interrupt on set ready change");

  a_ch1_irq_cts: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_ms_int_en[1] && $changed(i_cts_b[1])
    |=> o_irq[1])
    else $error("channel 1 no interrupt on clear to send change");

  a_ch1_irq_dcd: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    $past(i_rst_b) && i_ms_int_en[1] && $changed(i_dcd_b[1])
    |=> o_irq[1])
    else $error("channel 1 no interrupt on carrier change");

  a_ch1_irq_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_ms_int_en[1]
    |=> !o_irq[1])
    else $error("channel 1 interrupt while disabled");

  a_ch1_dtr_on: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b && !i_loopback[1] && i_modem_control_reg[1]
    |=> !o_dtr_b[1])
    else $error("channel 1 terminal ready not driven");

  a_ch1_dtr_off: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    !i_modem_control_reg[1]
    |=> o_dtr_b[1])
    else $error("channel 1 terminal ready driven while off");

  a_ch1_dtr_loop: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_loopback[1]
    |=> o_dtr_b[1])
    else $error("channel 1 terminal ready driven in loopback");

  a_ch1_dtr_reset: assert property (@(posedge i_clk_sys)
    !i_rst_b
    |-> o_dtr_b[1] && !o_irq[1] && o_modem_status_reg_1 == `UMH_MSR_RST)
    else $error("channel 1 outputs not idle in reset");

endmodule

//--- test/testbench.sv
// self-checking bench for the two-channel modem handshake block
// assumes one clock, status reads as one-cycle pulses
`timescale 1ns/10ps
module testbench;
  import umh_pkg::*;
  logic       i_clk_sys = 1'b0;
  logic       i_rst_b   = 1'b1;
  logic [1:0] cts = 2'h0, dsr = 2'h0, dcd = 2'h0, rd = 2'h0;
  logic [1:0] modem_control_reg = 2'h0, lb = 2'h0, en = 2'h3;
  logic [1:0] cts_b, dsr_b, dcd_b, dtr_b, irq;
  umh_byte_t  msr0, msr1;
  int         error_cnt = 0, comparisons = 0, cyc = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  umh_modem modem (.i_cts_on(cts), .i_dsr_on(dsr), .i_dcd_on(dcd),
    .o_cts_b(cts_b), .o_dsr_b(dsr_b), .o_dcd_b(dcd_b));
  umh_top dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_cts_b(cts_b),
    .i_dsr_b(dsr_b), .i_dcd_b(dcd_b), .i_msr_rd(rd), .i_modem_control_reg(modem_control_reg),
    .i_loopback(lb), .i_ms_int_en(en), .o_dtr_b(dtr_b),
    .o_modem_status_reg_0(msr0), .o_modem_status_reg_1(msr1), .o_irq(irq));
  task sync();
    @(posedge i_clk_sys);
  endtask
  task tick();
    @(posedge i_clk_sys);
    rd <= 2'h0;
    #1;
  endtask
  task chk_b(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t status %h expected %h", $time, g, e);
    end
  endtask
  task chk_p(input logic [1:0] g, input logic [1:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t pins %b expected %b", $time, g, e);
    end
  endtask
  task end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 400) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    i_rst_b <= 1'b0;
    repeat (5) @(posedge i_clk_sys);
    #1;
    chk_p(dtr_b, 2'h3);
    sync(); i_rst_b <= 1'b1; tick();
    sync(); dsr <= 2'h1; tick();
    chk_b(msr0, 8'h22);
    chk_p(irq, 2'h1);
    sync(); rd <= 2'h1; tick();
    chk_b(msr0, 8'h20);
    chk_p(irq, 2'h0);
    sync(); dsr <= 2'h0; tick();
    chk_b(msr0, 8'h02);
    $display("test set_ready done");
    sync(); en <= 2'h1; cts <= 2'h2; dcd <= 2'h2; tick();
    chk_b(msr1, 8'h99);
    chk_p(irq, 2'h1);
    sync(); en <= 2'h3; tick();
    chk_p(irq, 2'h3);
    sync(); rd <= 2'h3; cts <= 2'h0; tick();
    chk_b(msr1, 8'h81);
    chk_b(msr0, 8'h00);
    chk_p(irq, 2'h2);
    sync(); rd <= 2'h2; tick();
    chk_b(msr1, 8'h80);
    chk_p(irq, 2'h0);
    $display("test status flags done");
    sync(); modem_control_reg <= 2'h1; tick();
    chk_p(dtr_b, 2'h2);
    sync(); lb <= 2'h1; modem_control_reg <= 2'h3; tick();
    chk_p(dtr_b, 2'h1);
    sync(); lb <= 2'h0; tick();
    chk_p(dtr_b, 2'h0);
    sync(); i_rst_b <= 1'b0; dsr <= 2'h1; tick();
    chk_p(dtr_b, 2'h3);
    $display("test terminal ready done");
    sync(); i_rst_b <= 1'b1; tick();
    chk_b(msr0, 8'h22);
    chk_b(msr1, 8'h88);
    chk_p(irq, 2'h3);
    $display("test reset release done");
    end_sim();
  end
endmodule

//--- test/umh_modem.sv
// modem model for both channels: drives the three status lines
// assumes the bench asks for a line as an active-high level
`timescale 1ns/10ps
module umh_modem (
  input  wire logic [1:0] i_cts_on,
  input  wire logic [1:0] i_dsr_on,
  input  wire logic [1:0] i_dcd_on,
  output logic [1:0]      o_cts_b,
  output logic [1:0]      o_dsr_b,
  output logic [1:0]      o_dcd_b
);
  assign o_dsr_b = ~i_dsr_on;
  assign o_cts_b = ~i_cts_on;
  assign o_dcd_b = ~i_dcd_on;
endmodule
